// ===== dsd_defines.svh
// Constants for the dual sigma-delta / PWM wave generator
`ifndef DSD_DEFINES_SVH
`define DSD_DEFINES_SVH

// ****************************************
// Mode field codes
// ****************************************
`define DSD_MODE_OFF 3'h0
`define DSD_MODE_NRZ 3'h4
`define DSD_MODE_DUAL8 3'h5
`define DSD_MODE_RZ 3'h6

// ****************************************
// Clock source field codes
// ****************************************
`define DSD_SRC_XTAL15 2'h0
`define DSD_SRC_XTAL 2'h1
`define DSD_SRC_EXT 2'h2
`define DSD_SRC_VCO 2'h3

// ****************************************
// Divider field codes and terminal counts (ratio minus one)
// ****************************************
`define DSD_DIV_CODE_1 2'h0
`define DSD_DIV_CODE_4 2'h1
`define DSD_DIV_CODE_16 2'h2
`define DSD_DIV_CODE_64 2'h3
`define DSD_TERM_1 6'h00
`define DSD_TERM_4 6'h03
`define DSD_TERM_16 6'h0f
`define DSD_TERM_64 6'h3f
`define DSD_XTAL15_TERM 4'he

// ****************************************
// Density window and reset values
// ****************************************
`define DSD_WIN_START 16'h0000
`define DSD_WIN_LAST 16'hffff
`define DSD_SPREAD_EXAMPLE 16'h4010
`define DSD_ZERO_WORD 16'h0000
`define DSD_ZERO_BYTE 8'h00

`endif

// ===== dsd_pkg.sv
// Types shared by the wave generator files
package dsd_pkg;
`include "dsd_defines.svh"

   typedef logic [15:0] dsd_word_t;

   typedef enum logic [2:0] {
      DSD_OFF = `DSD_MODE_OFF,
      DSD_NRZ = `DSD_MODE_NRZ,
      DSD_DUAL8 = `DSD_MODE_DUAL8,
      DSD_RZ = `DSD_MODE_RZ
   } dsd_mode_e;

endpackage : dsd_pkg

// ===== dsd_rc_filter.sv
// Pin load model: integrates and counts rises on both wave outputs, times gaps and runs on output A only
`timescale 1ns/1ps
module dsd_rc_filter (
   input wire logic core_clk_in,
   input wire logic clear_in,
   input wire logic wave_a_in,
   input wire logic wave_b_in,
   output logic [31:0] high_a_out,
   output logic [31:0] high_b_out,
   output logic [31:0] rise_a_out,
   output logic [31:0] rise_b_out,
   output logic [31:0] min_gap_a_out,
   output logic [31:0] max_gap_a_out,
   output logic [31:0] max_run_a_out
);
   logic prev_a_r;
   logic prev_b_r;
   logic seen_a_r;
   logic [31:0] since_a_r;
   logic [31:0] run_a_r;

   // ****************************************
   // Charge and edge bookkeeping
   // ****************************************
   always_ff @(posedge core_clk_in) begin
      if (clear_in) begin
         high_a_out <= 32'h0;
         high_b_out <= 32'h0;
         rise_a_out <= 32'h0;
         rise_b_out <= 32'h0;
         min_gap_a_out <= 32'hffffffff;
         max_gap_a_out <= 32'h0;
         max_run_a_out <= 32'h0;
         // Pin level at clear is not an edge
         prev_a_r <= wave_a_in;
         prev_b_r <= wave_b_in;
         seen_a_r <= 1'b0;
         since_a_r <= 32'h0;
         run_a_r <= 32'h0;
      end else begin
         high_a_out <= high_a_out + {31'h0, wave_a_in};
         high_b_out <= high_b_out + {31'h0, wave_b_in};
         prev_a_r <= wave_a_in;
         prev_b_r <= wave_b_in;
         since_a_r <= since_a_r + 32'h1;
         run_a_r <= wave_a_in ? run_a_r + 32'h1 : 32'h0;
         if (wave_a_in && run_a_r + 32'h1 > max_run_a_out) begin
            max_run_a_out <= run_a_r + 32'h1;
         end
         if (wave_a_in && !prev_a_r) begin
            rise_a_out <= rise_a_out + 32'h1;
            since_a_r <= 32'h1;
            seen_a_r <= 1'b1;
            // First edge after clear has no known start
            if (seen_a_r && since_a_r < min_gap_a_out) begin
               min_gap_a_out <= since_a_r;
            end
            if (seen_a_r && since_a_r > max_gap_a_out) begin
               max_gap_a_out <= since_a_r;
            end
         end
         if (wave_b_in && !prev_b_r) begin
            rise_b_out <= rise_b_out + 32'h1;
         end
      end
   end
endmodule : dsd_rc_filter

// ===== dsd_tick_gen.sv
// Clock source select and prescaler producing the PWM tick enables
`timescale 1ns/1ps
`include "dsd_defines.svh"
module dsd_tick_gen (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [1:0] clock_source_field_in,
   input wire logic [1:0] clock_divide_field_in,
   input wire logic xtal_tick_in,
   input wire logic ext_clk_in,
   input wire logic vco_tick_in,
   output logic tick_out,
   output logic mid_out
);
   import dsd_pkg::*;

   logic ext_prev_r, ext_prev_nxt;
   logic [3:0] x15_r, x15_nxt;
   logic [5:0] pre_r, pre_nxt;
   logic tick_r, tick_nxt, mid_r, mid_nxt;
   logic sel, x15_hit;
   logic [5:0] term;

   // ****************************************
   // Source select and divider
   // ****************************************
   always_comb begin
      ext_prev_nxt = ext_clk_in;
      x15_hit = xtal_tick_in && (x15_r == `DSD_XTAL15_TERM);
      x15_nxt = x15_r;
      if (xtal_tick_in) begin
         x15_nxt = x15_hit ? 4'h0 : x15_r + 4'h1;
      end
      unique case (clock_source_field_in) // RL14
         `DSD_SRC_XTAL15: sel = x15_hit;
         `DSD_SRC_XTAL: sel = xtal_tick_in;
         `DSD_SRC_EXT: sel = ext_clk_in && !ext_prev_r;
         `DSD_SRC_VCO: sel = vco_tick_in;
      endcase
      unique case (clock_divide_field_in) // RL13
         `DSD_DIV_CODE_1: term = `DSD_TERM_1;
         `DSD_DIV_CODE_4: term = `DSD_TERM_4;
         `DSD_DIV_CODE_16: term = `DSD_TERM_16;
         `DSD_DIV_CODE_64: term = `DSD_TERM_64;
      endcase
      pre_nxt = pre_r;
      if (sel) begin
         pre_nxt = (pre_r >= term) ? 6'h00 : pre_r + 6'h01;
      end
      tick_nxt = sel && (pre_r >= term);
      // No half period exists at divide by one: low after one core cycle
      if (term == `DSD_TERM_1) begin
         mid_nxt = tick_r;
      end else begin
         mid_nxt = sel && (pre_r == (term >> 1));
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         ext_prev_r <= 1'b0;
         x15_r <= 4'h0;
         pre_r <= 6'h00;
         tick_r <= 1'b0;
         mid_r <= 1'b0;
      end else begin
         ext_prev_r <= ext_prev_nxt;
         x15_r <= x15_nxt;
         pre_r <= pre_nxt;
         tick_r <= tick_nxt;
         mid_r <= mid_nxt;
      end
   end

   assign tick_out = tick_r;
   assign mid_out = mid_r;

   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);

   property p_src_xtal;
      (clock_source_field_in == `DSD_SRC_XTAL && $stable(clock_source_field_in)
       && clock_divide_field_in == `DSD_DIV_CODE_1 && tick_r)
      |-> $past(xtal_tick_in);
   endproperty
   a_src_xtal: assert property (p_src_xtal) // RL14
      else $error("tick without crystal tick at source 01");

   property p_div16;
      (tick_r && clock_divide_field_in == `DSD_DIV_CODE_16
       && $stable(clock_divide_field_in))
      |-> $past(pre_r) == `DSD_TERM_16 && $past(sel);
   endproperty
   a_div16: assert property (p_div16) // RL13
      else $error("divide by 16 tick off the 16th source tick");

endmodule : dsd_tick_gen

// ===== dsd_wave_gen.sv
// Dual output sigma-delta and dual 8-bit PWM wave generator
//
// How it works
// RL1: NRZ mode updates both outputs on every divided PWM tick.
// RL2: NRZ: each output high exactly duty ticks per 65536-tick window.
// RL3: High ticks are spread evenly by a first-order accumulator.
// RL4: Software pads unused low duty bits with zeros and a final one.
// RL5: Software normally runs NRZ mode from the undivided PLL clock.
// RL6: Dual 8-bit: channel A period low byte, channel B high byte.
// RL7: Dual 8-bit: duty A from low byte, duty B from high byte.
// RL8: Dual 8-bit channels share one source select and one divider.
// RL9: RZ mode uses the same duty words and 65536-tick density sequence.
// RL10: RZ: a high tick is high first half, low second half.
// RL11: Software should use divide by 4 in RZ mode.
// RL12: Mode 100 NRZ, 101 dual 8-bit, 110 RZ; others drive low.
// RL13: Divider code 00..11 divides the selected clock by 1,4,16,64.
// RL14: Source code 00..11: crystal/15, crystal, external pin, PLL.
// RL15: Dual 8-bit counter runs 0..period; high while below duty.
// RL16: New duty and period apply only at next cycle or window.
`timescale 1ns/1ps
`include "dsd_defines.svh"
module dsd_wave_gen (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [2:0] mode_select_field_in,
   input wire logic [1:0] clock_divide_field_in,
   input wire logic [1:0] clock_source_field_in,
   input wire logic xtal_tick_in,
   input wire logic ext_clk_in,
   input wire logic vco_tick_in,
   input wire dsd_pkg::dsd_word_t duty_a_word_in,
   input wire dsd_pkg::dsd_word_t duty_b_word_in,
   output logic wave_out_a_pin_out,
   output logic wave_out_b_pin_out,
   output logic wave_drive_en_out
);
   import dsd_pkg::*;

   logic tick, mid;
   dsd_mode_e mode_r, mode_nxt, mode_now;
   logic restart;
   dsd_word_t win_r, win_nxt;
   dsd_word_t acc_a_r, acc_a_nxt, acc_b_r, acc_b_nxt;
   dsd_word_t sd_dut_a_r, sd_dut_a_nxt, sd_dut_b_r, sd_dut_b_nxt;
   dsd_word_t p8_a_r, p8_a_nxt, p8_b_r, p8_b_nxt;
   logic [7:0] cnt_a_r, cnt_a_nxt, cnt_b_r, cnt_b_nxt;
   logic out_a_r, out_a_nxt, out_b_r, out_b_nxt;
   logic drive_en_r, drive_en_nxt;
   logic [16:0] hcnt_a_r, hcnt_a_nxt, hcnt_b_r, hcnt_b_nxt;
   logic [16:0] sd_a, sd_b;
   logic [8:0] pw_a, pw_b;
   dsd_word_t use_a, use_b, p8_use_a, p8_use_b;

   // Shared source and divider keep both channels in step
   dsd_tick_gen u_tick ( // RL8
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .clock_source_field_in(clock_source_field_in),
      .clock_divide_field_in(clock_divide_field_in),
      .xtal_tick_in(xtal_tick_in),
      .ext_clk_in(ext_clk_in),
      .vco_tick_in(vco_tick_in),
      .tick_out(tick),
      .mid_out(mid)
   );

   // ****************************************
   // Step functions
   // ****************************************
   // Carry out is the output bit; carries over 65536 steps equal duty
   function automatic logic [16:0] sd_step(input dsd_word_t acc,
                                           input dsd_word_t duty);
      sd_step = {1'b0, acc} + {1'b0, duty};
   endfunction : sd_step

   function automatic logic [8:0] pwm_step(input logic [7:0] cnt,
                                           input logic [7:0] per,
                                           input logic [7:0] duty);
      logic lvl;
      logic [7:0] nxt;
      lvl = cnt < duty;
      nxt = (cnt >= per) ? `DSD_ZERO_BYTE : cnt + 8'h01;
      pwm_step = {lvl, nxt};
   endfunction : pwm_step

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      unique case (mode_select_field_in) // RL12
         `DSD_MODE_NRZ: mode_now = DSD_NRZ;
         `DSD_MODE_DUAL8: mode_now = DSD_DUAL8;
         `DSD_MODE_RZ: mode_now = DSD_RZ;
         default: mode_now = DSD_OFF;
      endcase
      restart = mode_now != mode_r;
      // Words are sampled only at window or cycle start
      use_a = (win_r == `DSD_WIN_START) ? duty_a_word_in : sd_dut_a_r; // RL16
      use_b = (win_r == `DSD_WIN_START) ? duty_b_word_in : sd_dut_b_r;
      sd_a = sd_step(acc_a_r, use_a); // RL3
      sd_b = sd_step(acc_b_r, use_b);
      p8_use_a = (cnt_a_r == `DSD_ZERO_BYTE) ? // RL16
         {duty_b_word_in[7:0], duty_a_word_in[7:0]} : p8_a_r; // RL6 RL7
      p8_use_b = (cnt_b_r == `DSD_ZERO_BYTE) ?
         {duty_b_word_in[15:8], duty_a_word_in[15:8]} : p8_b_r; // RL6 RL7
      pw_a = pwm_step(cnt_a_r, p8_use_a[15:8], p8_use_a[7:0]); // RL15
      pw_b = pwm_step(cnt_b_r, p8_use_b[15:8], p8_use_b[7:0]); // RL15
      mode_nxt = mode_r;
      win_nxt = win_r;
      acc_a_nxt = acc_a_r;
      acc_b_nxt = acc_b_r;
      sd_dut_a_nxt = sd_dut_a_r;
      sd_dut_b_nxt = sd_dut_b_r;
      p8_a_nxt = p8_a_r;
      p8_b_nxt = p8_b_r;
      cnt_a_nxt = cnt_a_r;
      cnt_b_nxt = cnt_b_r;
      out_a_nxt = out_a_r;
      out_b_nxt = out_b_r;
      drive_en_nxt = drive_en_r;
      hcnt_a_nxt = hcnt_a_r;
      hcnt_b_nxt = hcnt_b_r;
      if (restart) begin
         // Any mode change starts a fresh window or cycle
         mode_nxt = mode_now;
         win_nxt = `DSD_WIN_START;
         acc_a_nxt = `DSD_ZERO_WORD;
         acc_b_nxt = `DSD_ZERO_WORD;
         cnt_a_nxt = `DSD_ZERO_BYTE;
         cnt_b_nxt = `DSD_ZERO_BYTE;
         out_a_nxt = 1'b0;
         out_b_nxt = 1'b0;
         drive_en_nxt = mode_now != DSD_OFF; // RL12
         hcnt_a_nxt = 17'h0;
         hcnt_b_nxt = 17'h0;
      end else begin
         unique case (mode_r)
            DSD_NRZ, DSD_RZ: begin
               if (tick) begin // RL1 RL9
                  win_nxt = win_r + 16'h1;
                  sd_dut_a_nxt = use_a;
                  sd_dut_b_nxt = use_b;
                  acc_a_nxt = sd_a[15:0];
                  acc_b_nxt = sd_b[15:0];
                  out_a_nxt = sd_a[16]; // RL2
                  out_b_nxt = sd_b[16];
                  hcnt_a_nxt = ((win_r == `DSD_WIN_START) ? 17'h0 : hcnt_a_r)
                     + {16'h0, sd_a[16]};
                  hcnt_b_nxt = ((win_r == `DSD_WIN_START) ? 17'h0 : hcnt_b_r)
                     + {16'h0, sd_b[16]};
               end else if (mid && mode_r == DSD_RZ) begin
                  out_a_nxt = 1'b0; // RL10
                  out_b_nxt = 1'b0;
               end
            end
            DSD_DUAL8: begin
               if (tick) begin // RL8
                  p8_a_nxt = p8_use_a;
                  p8_b_nxt = p8_use_b;
                  cnt_a_nxt = pw_a[7:0];
                  cnt_b_nxt = pw_b[7:0];
                  out_a_nxt = pw_a[8];
                  out_b_nxt = pw_b[8];
               end
            end
            DSD_OFF: begin
               out_a_nxt = 1'b0; // RL12
               out_b_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         mode_r <= DSD_OFF;
         win_r <= `DSD_WIN_START;
         acc_a_r <= `DSD_ZERO_WORD;
         acc_b_r <= `DSD_ZERO_WORD;
         sd_dut_a_r <= `DSD_ZERO_WORD;
         sd_dut_b_r <= `DSD_ZERO_WORD;
         p8_a_r <= `DSD_ZERO_WORD;
         p8_b_r <= `DSD_ZERO_WORD;
         cnt_a_r <= `DSD_ZERO_BYTE;
         cnt_b_r <= `DSD_ZERO_BYTE;
         out_a_r <= 1'b0;
         out_b_r <= 1'b0;
         drive_en_r <= 1'b0;
         hcnt_a_r <= 17'h0;
         hcnt_b_r <= 17'h0;
      end else begin
         mode_r <= mode_nxt;
         win_r <= win_nxt;
         acc_a_r <= acc_a_nxt;
         acc_b_r <= acc_b_nxt;
         sd_dut_a_r <= sd_dut_a_nxt;
         sd_dut_b_r <= sd_dut_b_nxt;
         p8_a_r <= p8_a_nxt;
         p8_b_r <= p8_b_nxt;
         cnt_a_r <= cnt_a_nxt;
         cnt_b_r <= cnt_b_nxt;
         out_a_r <= out_a_nxt;
         out_b_r <= out_b_nxt;
         drive_en_r <= drive_en_nxt;
         hcnt_a_r <= hcnt_a_nxt;
         hcnt_b_r <= hcnt_b_nxt;
      end
   end

   assign wave_out_a_pin_out = out_a_r;
   assign wave_out_b_pin_out = out_b_r;
   assign wave_drive_en_out = drive_en_r;

   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);

   property p_nrz_update;
      (mode_r == DSD_NRZ && $past(mode_r) == DSD_NRZ && !$past(tick))
      |-> $stable(out_a_r) && $stable(out_b_r);
   endproperty
   a_nrz_update: assert property (p_nrz_update) // RL1
      else $error("NRZ output moved without a tick");

   property p_nrz_density;
      (mode_r == DSD_NRZ && win_r == `DSD_WIN_START
       && $past(win_r) == `DSD_WIN_LAST && $past(tick))
      |-> hcnt_a_r == {1'b0, sd_dut_a_r};
   endproperty
   a_nrz_density: assert property (p_nrz_density) // RL2
      else $error("NRZ high count differs from duty A");

   // Channel A carries the quarter scale word in the long window test
   property p_spread;
      (mode_r == DSD_NRZ && $stable(mode_r) && tick
       && sd_dut_a_r == `DSD_SPREAD_EXAMPLE
       && win_r != `DSD_WIN_START && out_a_r)
      |=> !out_a_r;
   endproperty
   a_spread: assert property (p_spread) // RL3
      else $error("high run longer than one tick at quarter scale");

   // Both sigma-delta modes share one window, so one check covers both
   property p_rz_density;
      ((mode_r == DSD_RZ || mode_r == DSD_NRZ)
       && win_r == `DSD_WIN_START
       && $past(win_r) == `DSD_WIN_LAST && $past(tick))
      |-> hcnt_b_r == {1'b0, sd_dut_b_r};
   endproperty
   a_rz_density: assert property (p_rz_density) // RL9
      else $error("window high count differs from duty B");

   property p_rz_half;
      (mode_r == DSD_RZ && mode_now == DSD_RZ && mid && !tick)
      |=> !out_a_r && !out_b_r;
   endproperty
   a_rz_half: assert property (p_rz_half) // RL10
      else $error("RZ output not returned low at mid tick");

   property p_period;
      (mode_r == DSD_DUAL8)
      |-> cnt_a_r <= p8_a_r[15:8] && cnt_b_r <= p8_b_r[15:8];
   endproperty
   a_period: assert property (p_period) // RL6
      else $error("8-bit counter beyond its period");

   property p_duty_b;
      (mode_r == DSD_DUAL8 && mode_now == DSD_DUAL8 && tick
       && cnt_b_r == `DSD_ZERO_BYTE)
      |=> out_b_r == ($past(duty_a_word_in[15:8]) != `DSD_ZERO_BYTE);
   endproperty
   a_duty_b: assert property (p_duty_b) // RL7
      else $error("channel B start level not from duty high byte");

   property p_shared_tick;
      (mode_r == DSD_DUAL8 && $past(mode_r) == DSD_DUAL8 && !$past(tick))
      |-> $stable(cnt_a_r) && $stable(cnt_b_r);
   endproperty
   a_shared_tick: assert property (p_shared_tick) // RL8
      else $error("8-bit counter moved without shared tick");

   property p_low_past_duty;
      (mode_r == DSD_DUAL8 && mode_now == DSD_DUAL8 && tick
       && cnt_a_r != `DSD_ZERO_BYTE && cnt_a_r >= p8_a_r[7:0])
      |=> !out_a_r;
   endproperty
   a_low_past_duty: assert property (p_low_past_duty) // RL15
      else $error("channel A high at or past its duty");

   property p_off_low;
      (mode_select_field_in != `DSD_MODE_NRZ
       && mode_select_field_in != `DSD_MODE_DUAL8
       && mode_select_field_in != `DSD_MODE_RZ)
      |=> !out_a_r && !out_b_r && !drive_en_r;
   endproperty
   a_off_low: assert property (p_off_low) // RL12
      else $error("outputs active in disabled or reserved mode");

   property p_hold_words;
      (mode_r == DSD_DUAL8 && mode_now == DSD_DUAL8
       && cnt_a_r != `DSD_ZERO_BYTE)
      |=> $stable(p8_a_r);
   endproperty
   a_hold_words: assert property (p_hold_words) // RL16
      else $error("channel A settings changed mid cycle");

endmodule : dsd_wave_gen

// ===== tb_top.sv
// Self-checking bench for the dual wave generator
`timescale 1ns/1ps
module tb_top;
   import dsd_pkg::*;
   logic core_clk_in;
   logic reset_in;
   logic [2:0] mode_r;
   logic [1:0] div_r;
   logic [1:0] src_r;
   logic [1:0] gen_r;
   logic clear_r;
   dsd_word_t duty_a_r;
   dsd_word_t duty_b_r;
   logic wave_a;
   logic wave_b;
   logic drive_en;
   logic [31:0] high_a, high_b, rise_a, rise_b, min_gap, max_gap, max_run;
   logic [2:0] off_list [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   logic [31:0] src_gap [4] = '{32'h3c, 32'h4, 32'h8, 32'h2};
   int err_count;
   int checks;

   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   // Crystal pulses every other cycle, ext pin rises every fourth
   always @(posedge core_clk_in) gen_r <= gen_r + 2'h1;

   dsd_wave_gen dsd_wave_gen_i (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .mode_select_field_in(mode_r),
      .clock_divide_field_in(div_r),
      .clock_source_field_in(src_r),
      .xtal_tick_in(gen_r[0]),
      .ext_clk_in(gen_r[1]),
      .vco_tick_in(1'b1),
      .duty_a_word_in(duty_a_r),
      .duty_b_word_in(duty_b_r),
      .wave_out_a_pin_out(wave_a),
      .wave_out_b_pin_out(wave_b),
      .wave_drive_en_out(drive_en));

   dsd_rc_filter dsd_rc_filter_i (
      .core_clk_in(core_clk_in),
      .clear_in(clear_r),
      .wave_a_in(wave_a),
      .wave_b_in(wave_b),
      .high_a_out(high_a),
      .high_b_out(high_b),
      .rise_a_out(rise_a),
      .rise_b_out(rise_b),
      .min_gap_a_out(min_gap),
      .max_gap_a_out(max_gap),
      .max_run_a_out(max_run));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : check

   task automatic results;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   // Passing through off forces a clean restart of window and counters
   task automatic set_cfg(input logic [2:0] m, input logic [1:0] s,
         input logic [1:0] d, input dsd_word_t da, input dsd_word_t db);
      @(posedge core_clk_in);
      mode_r <= 3'h0;
      src_r <= s;
      div_r <= d;
      duty_a_r <= da;
      duty_b_r <= db;
      @(posedge core_clk_in);
      mode_r <= m;
      repeat (200) @(posedge core_clk_in);
   endtask : set_cfg

   task automatic measure(input int n);
      @(posedge core_clk_in);
      clear_r <= 1'b1;
      @(posedge core_clk_in);
      clear_r <= 1'b0;
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : measure

   task automatic dual_case(input logic [1:0] d, input dsd_word_t da,
         input dsd_word_t db, input int n, input logic [31:0] ha,
         input logic [31:0] hb, input logic [31:0] ra, input logic [31:0] rb);
      set_cfg(DSD_DUAL8, 2'h3, d, da, db);
      measure(n);
      check(high_a, ha);
      check(high_b, hb);
      check(rise_a, ra);
      check(rise_b, rb);
      $display("test dual 8-bit done");
   endtask : dual_case

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (100000) @(posedge core_clk_in);
      err_count++;
      $display("test sequence timed out");
      results();
   end

   initial begin
      err_count = 0;
      checks = 0;
      gen_r = 2'h0;
      reset_in = 1'b1;
      clear_r = 1'b1;
      mode_r = 3'h4;
      src_r = 2'h3;
      div_r = 2'h0;
      duty_a_r = 16'hffff;
      duty_b_r = 16'hffff;
      repeat (16) @(posedge core_clk_in);
      check({29'h0, drive_en, wave_a, wave_b}, 32'h0);
      reset_in <= 1'b0;
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         set_cfg(off_list[i], 2'h3, 2'h0, 16'hffff, 16'hffff);
         check({31'h0, drive_en}, 32'h0);
         measure(64);
         check(high_a + high_b, 32'h0);
      end
      $display("test off codes done");
      // Undivided PLL clock, 8-bit padded duty on B
      set_cfg(DSD_NRZ, 2'h3, 2'h0, 16'h4010, 16'h8001);
      check({31'h0, drive_en}, 32'h1);
      measure(65536);
      check(high_a, 32'h4010);
      check(high_b, 32'h8001);
      check(max_run, 32'h1);
      check(min_gap, 32'h3);
      check(max_gap, 32'h4);
      $display("test full density window done");
      set_cfg(DSD_RZ, 2'h3, 2'h1, 16'h4000, 16'hc000);
      measure(256);
      check(rise_a, 32'h10);
      check(rise_b, 32'h30);
      check(high_a, 32'h20);
      check(high_b, 32'h60);
      $display("test return to zero done");
      dual_case(2'h0, 16'h0302, 16'h0903, 40, 32'h14, 32'hc, 32'ha, 32'h4);
      dual_case(2'h1, 16'h0302, 16'h0903, 160, 32'h50, 32'h30, 32'ha,
         32'h4);
      dual_case(2'h0, 16'h0a00, 16'h0903, 40, 32'h0, 32'h28, 32'h0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         set_cfg(DSD_NRZ, 2'h3, i[1:0], 16'h8000, 16'h0000);
         measure(32 << (2 * i));
         check(min_gap, 32'h2 << (2 * i));
         check(max_gap, 32'h2 << (2 * i));
      end
      $display("test divider codes done");
      for (int i = 0; i < 4; i++) begin
         set_cfg(DSD_NRZ, i[1:0], 2'h0, 16'h8000, 16'h0000);
         measure(src_gap[i] * 8);
         check(min_gap, src_gap[i]);
         check(max_gap, src_gap[i]);
      end
      $display("test clock sources done");
      results();
   end
endmodule : tb_top
